// ==== pkg/ihs_pkg.sv ====
// shared types and constants for the two-wire host sequencer
package ihs_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int RATE_W = 8;
  localparam int DATA_W = 8;
  localparam int BIT_W  = 4;
  localparam int SYNC_N = 3;

  // ----------------------------------------------------------------
  // counts and constant levels
  // ----------------------------------------------------------------
  localparam logic [RATE_W-1:0] RATE_ZERO = 8'h00;
  localparam logic [RATE_W-1:0] RATE_ONE  = 8'h01;
  localparam logic [BIT_W-1:0]  BIT_FIRST = 4'h0;
  localparam logic [BIT_W-1:0]  BIT_ONE   = 4'h1;
  localparam logic [BIT_W-1:0]  BIT_LAST  = 4'h7;
  localparam logic [BIT_W-1:0]  BIT_ACK   = 4'h8;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
  localparam int                DATA_MSB  = DATA_W - 1;
  localparam logic              LINE_LOW  = 1'h0;
  localparam logic              FLAG_OFF  = 1'h0;
  localparam logic              FLAG_ON   = 1'h1;

  // sequence requested by the system side
  typedef enum logic [2:0] {
    CMD_NONE,
    CMD_START,
    CMD_RESTART,
    CMD_STOP,
    CMD_ACK,
    CMD_SEND
  } ihs_cmd_e;

  // request carried across to the link domain, held stable while busy
  typedef struct packed {
    ihs_cmd_e          op;
    logic [DATA_W-1:0] data;
    logic              ackValue;
    logic [RATE_W-1:0] reload;
  } ihs_cmd_s;

  localparam ihs_cmd_s CMD_RESET = '{CMD_NONE, DATA_ZERO, FLAG_OFF,
                                     RATE_ZERO};

  // sequencer states in the link domain
  typedef enum logic [4:0] {
    L_IDLE,
    L_ST_HIGH,
    L_ST_LOW,
    L_RS_REL,
    L_RS_WAIT,
    L_AK_LOW,
    L_AK_WAIT,
    L_AK_HIGH,
    L_SP_DRIVE,
    L_SP_LOW,
    L_SP_REL,
    L_SP_WAIT,
    L_SP_DONE,
    L_TX_LOW,
    L_TX_WAIT,
    L_TX_HIGH
  } ihs_state_e;

endpackage

// ==== logic/ihs_host_seq.sv ====
// two-wire bus host sequencer: start, restart, stop, ack, send, arbitration
// ----------------------------------------------------------------------
// Overview of operation
// - ack enable holds clock low, drives ack data
// - ack: one period, release clock, one more
// - ack end clears enable, stops counter, idles
// - buffer write during ack sets write collision
// - stop drives data low, then counts period
// - stop expiry releases clock, data one period later
// - stop seen, period later clear enable, event
// - buffer write during stop sets write collision
// - reset disables port and aborts transfer
// - start/stop detected cleared by reset, disable
// - busy bus stop raises port event
// - released data sampled low flags collision
// - send collision clears buffer full, releases lines
// - sequence collision aborts and clears its enable
// - after collision, bus stop sets port event
// - next write restarts from first data bit
// - start with a line low flags collision
// - start: clock low while data high collides
// - data low early asserts start data early
// - start hold ignores clock, then clock low
// - each period reloads from rate reload value
// ----------------------------------------------------------------------
module ihs_host_seq
  import ihs_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              resetn,
  input  wire logic              linkClk,
  input  wire logic              moduleEnable,
  input  wire logic              startSet,
  input  wire logic              restartSet,
  input  wire logic              stopSet,
  input  wire logic              ackSet,
  input  wire logic              ack_data_value,
  input  wire logic [RATE_W-1:0] rate_reload_register,
  input  wire logic              bufWrite,
  input  wire logic [DATA_W-1:0] bufWriteData,
  input  wire logic              writeCollisionClear,
  input  wire logic              portEventClear,
  input  wire logic              busCollisionClear,
  input  wire logic              sclIn,
  input  wire logic              sdaIn,
  output logic                   start_sequence_enable,
  output logic                   restart_sequence_enable,
  output logic                   stop_sequence_enable,
  output logic                   ack_sequence_enable,
  output logic                   write_collision_flag,
  output logic                   buffer_full_flag,
  output logic                   port_event_flag,
  output logic                   bus_collision_flag,
  output logic                   startDetected,
  output logic                   stopDetected,
  output logic                   ackStatus,
  output logic                   sclOut,
  output logic                   sclOe,
  output logic                   sdaOut,
  output logic                   sdaOe
);

  // ----------------------------------------------------------------
  // system side: request issue
  // ----------------------------------------------------------------
  ihs_cmd_s          reqCmd;
  logic              reqToggle;
  logic              busy;
  logic [SYNC_N-1:0] sysSync1;
  logic [SYNC_N-1:0] sysSync2;
  logic [SYNC_N-1:0] sysSeen;
  logic              doneEdge;
  logic              busStartEdge;
  logic              busStopEdge;
  logic              canIssue;
  logic              doneToggle;
  logic              doneCollide;
  logic              doneAck;
  logic              startToggle;
  logic              stopToggle;

  assign canIssue     = moduleEnable && !busy;
  assign doneEdge     = sysSync2[2] ^ sysSeen[2];
  assign busStartEdge = sysSync2[1] ^ sysSeen[1];
  assign busStopEdge  = sysSync2[0] ^ sysSeen[0];

  // link events arrive as toggles; edges are taken after two stages
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      sysSync1 <= '0;
      sysSync2 <= '0;
      sysSeen  <= '0;
    end else begin
      sysSync1 <= {doneToggle, startToggle, stopToggle};
      sysSync2 <= sysSync1;
      sysSeen  <= sysSync2;
    end
  end

  // one sequence at a time; later requests while busy are ignored
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      reqCmd                  <= CMD_RESET;
      reqToggle               <= FLAG_OFF;
      busy                    <= FLAG_OFF;
      buffer_full_flag        <= FLAG_OFF;
      start_sequence_enable   <= FLAG_OFF;
      restart_sequence_enable <= FLAG_OFF;
      stop_sequence_enable    <= FLAG_OFF;
      ack_sequence_enable     <= FLAG_OFF;
    end else if (!moduleEnable) begin
      busy                    <= FLAG_OFF;
      buffer_full_flag        <= FLAG_OFF;
      start_sequence_enable   <= FLAG_OFF;
      restart_sequence_enable <= FLAG_OFF;
      stop_sequence_enable    <= FLAG_OFF;
      ack_sequence_enable     <= FLAG_OFF;
    end else if (busy) begin
      if (doneEdge) begin
        // ending clears every enable, collision or not
        busy                    <= FLAG_OFF;
        buffer_full_flag        <= FLAG_OFF;
        start_sequence_enable   <= FLAG_OFF;
        restart_sequence_enable <= FLAG_OFF;
        stop_sequence_enable    <= FLAG_OFF;
        ack_sequence_enable     <= FLAG_OFF;
      end
    end else if (canIssue) begin
      reqCmd.reload   <= rate_reload_register;
      reqCmd.ackValue <= ack_data_value;
      if (startSet) begin
        reqCmd.op             <= CMD_START;
        start_sequence_enable <= FLAG_ON;
        reqToggle             <= ~reqToggle;
        busy                  <= FLAG_ON;
      end else if (restartSet) begin
        reqCmd.op               <= CMD_RESTART;
        restart_sequence_enable <= FLAG_ON;
        reqToggle               <= ~reqToggle;
        busy                    <= FLAG_ON;
      end else if (stopSet) begin
        reqCmd.op            <= CMD_STOP;
        stop_sequence_enable <= FLAG_ON;
        reqToggle            <= ~reqToggle;
        busy                 <= FLAG_ON;
      end else if (ackSet) begin
        reqCmd.op           <= CMD_ACK;
        ack_sequence_enable <= FLAG_ON;
        reqToggle           <= ~reqToggle;
        busy                <= FLAG_ON;
      end else if (bufWrite) begin
        reqCmd.op        <= CMD_SEND;
        reqCmd.data      <= bufWriteData;
        buffer_full_flag <= FLAG_ON;
        reqToggle        <= ~reqToggle;
        busy             <= FLAG_ON;
      end
    end
  end

  // ----------------------------------------------------------------
  // system side: status flags
  // ----------------------------------------------------------------
  // a write that lands while busy is dropped; set wins over clear
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      write_collision_flag <= FLAG_OFF;
    end else if (bufWrite && busy && moduleEnable) begin
      write_collision_flag <= FLAG_ON;
    end else if (writeCollisionClear) begin
      write_collision_flag <= FLAG_OFF;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      bus_collision_flag <= FLAG_OFF;
    end else if (busy && doneEdge && doneCollide) begin
      bus_collision_flag <= FLAG_ON;
    end else if (busCollisionClear) begin
      bus_collision_flag <= FLAG_OFF;
    end
  end

  // own completion without a collision, or a stop on a busy bus, raises the port event
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      port_event_flag <= FLAG_OFF;
    end else if (moduleEnable && busy && doneEdge && !doneCollide) begin
      port_event_flag <= FLAG_ON;
    end else if (moduleEnable && busStopEdge && startDetected) begin
      port_event_flag <= FLAG_ON;
    end else if (portEventClear) begin
      port_event_flag <= FLAG_OFF;
    end
  end

  // bus-free tracking; software checks these before a start
  always_ff @(posedge clk_sys) begin
    if (!resetn || !moduleEnable) begin
      startDetected <= FLAG_OFF;
      stopDetected  <= FLAG_OFF;
    end else if (busStopEdge) begin
      startDetected <= FLAG_OFF;
      stopDetected  <= FLAG_ON;
    end else if (busStartEdge) begin
      startDetected <= FLAG_ON;
      stopDetected  <= FLAG_OFF;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ackStatus <= FLAG_OFF;
    end else if (busy && doneEdge && reqCmd.op == CMD_SEND) begin
      ackStatus <= doneAck;
    end
  end

  // ----------------------------------------------------------------
  // link side: synchronisers
  // ----------------------------------------------------------------
  logic [4:0] linkSync1;
  logic [4:0] linkSync2;
  logic       linkRstn;
  logic       linkEnable;
  logic       reqSync;
  logic       sclSync;
  logic       sdaSync;
  logic       sclPrev;
  logic       sdaPrev;

  always_ff @(posedge linkClk) begin
    linkSync1 <= {resetn, moduleEnable, reqToggle, sclIn, sdaIn};
    linkSync2 <= linkSync1;
  end

  assign linkRstn   = linkSync2[4];
  assign linkEnable = linkSync2[3];
  assign reqSync    = linkSync2[2];
  assign sclSync    = linkSync2[1];
  assign sdaSync    = linkSync2[0];

  // ----------------------------------------------------------------
  // link side: bus monitor
  // ----------------------------------------------------------------
  // watches the lines even after losing arbitration
  always_ff @(posedge linkClk) begin
    if (!linkRstn) begin
      sclPrev     <= FLAG_ON;
      sdaPrev     <= FLAG_ON;
      startToggle <= FLAG_OFF;
      stopToggle  <= FLAG_OFF;
    end else begin
      sclPrev <= sclSync;
      sdaPrev <= sdaSync;
      if (sclSync && sclPrev && sdaPrev && !sdaSync) begin
        startToggle <= ~startToggle;
      end
      if (sclSync && sclPrev && !sdaPrev && sdaSync) begin
        stopToggle <= ~stopToggle;
      end
    end
  end

  // ----------------------------------------------------------------
  // link side: sequencer
  // ----------------------------------------------------------------
  ihs_state_e        state;
  ihs_cmd_s          cmd;
  logic              reqSeen;
  logic [RATE_W-1:0] rate_counter;
  logic [BIT_W-1:0]  bitIdx;
  logic [DATA_W-1:0] shifter;
  logic              sclDrive;
  logic              sdaDrive;
  logic              rateDone;

  assign rateDone = (rate_counter == RATE_ZERO);

  always_ff @(posedge linkClk) begin
    if (!linkRstn) begin
      state        <= L_IDLE;
      cmd          <= CMD_RESET;
      reqSeen      <= FLAG_OFF;
      rate_counter <= RATE_ZERO;
      bitIdx       <= BIT_FIRST;
      shifter      <= DATA_ZERO;
      sclDrive     <= FLAG_OFF;
      sdaDrive     <= FLAG_OFF;
      doneToggle   <= FLAG_OFF;
      doneCollide  <= FLAG_OFF;
      doneAck      <= FLAG_OFF;
    end else if (!linkEnable) begin
      // disabled port lets go of both lines at once
      state        <= L_IDLE;
      reqSeen      <= reqSync;
      rate_counter <= RATE_ZERO;
      sclDrive     <= FLAG_OFF;
      sdaDrive     <= FLAG_OFF;
    end else if (state != L_IDLE && sdaDrive == FLAG_OFF && sclSync &&
                 !sdaSync && (state == L_AK_HIGH ||
                 (state == L_TX_HIGH && bitIdx != BIT_ACK))) begin
      // lost arbitration on a released one: abandon, free both lines
      state        <= L_IDLE;
      rate_counter <= RATE_ZERO;
      sclDrive     <= FLAG_OFF;
      sdaDrive     <= FLAG_OFF;
      doneCollide  <= FLAG_ON;
      doneToggle   <= ~doneToggle;
    end else begin
      case (state)
        L_IDLE: begin
          rate_counter <= RATE_ZERO;
          if (reqSync != reqSeen) begin
            reqSeen      <= reqSync;
            cmd          <= reqCmd;
            doneCollide  <= FLAG_OFF;
            rate_counter <= reqCmd.reload;
            case (reqCmd.op)
              CMD_START: begin
                if (!sclSync || !sdaSync) begin
                  doneCollide <= FLAG_ON;
                  doneToggle  <= ~doneToggle;
                  sclDrive    <= FLAG_OFF;
                  sdaDrive    <= FLAG_OFF;
                end else begin
                  state <= L_ST_HIGH;
                end
              end
              CMD_RESTART: begin
                sdaDrive <= FLAG_OFF;
                state    <= L_RS_REL;
              end
              CMD_STOP: begin
                sclDrive <= FLAG_ON;
                sdaDrive <= FLAG_ON;
                state    <= L_SP_DRIVE;
              end
              CMD_ACK: begin
                sclDrive <= FLAG_ON;
                sdaDrive <= ~reqCmd.ackValue;
                state    <= L_AK_LOW;
              end
              CMD_SEND: begin
                // always from the top bit, whatever was cut short
                shifter  <= reqCmd.data;
                bitIdx   <= BIT_FIRST;
                sclDrive <= FLAG_ON;
                sdaDrive <= ~reqCmd.data[DATA_MSB];
                state    <= L_TX_LOW;
              end
              default: begin
                doneToggle <= ~doneToggle;
              end
            endcase
          end
        end
        L_ST_HIGH: begin
          if (!sdaSync) begin
            sdaDrive     <= FLAG_ON;
            rate_counter <= cmd.reload;
            state        <= L_ST_LOW;
          end else if (!sclSync) begin
            state       <= L_IDLE;
            sclDrive    <= FLAG_OFF;
            sdaDrive    <= FLAG_OFF;
            doneCollide <= FLAG_ON;
            doneToggle  <= ~doneToggle;
          end else if (rateDone) begin
            sdaDrive     <= FLAG_ON;
            rate_counter <= cmd.reload;
            state        <= L_ST_LOW;
          end else begin
            rate_counter <= rate_counter - RATE_ONE;
          end
        end
        L_ST_LOW: begin
          // clock level is ignored here: the other host may be early
          if (rateDone) begin
            sclDrive   <= FLAG_ON;
            state      <= L_IDLE;
            doneToggle <= ~doneToggle;
          end else begin
            rate_counter <= rate_counter - RATE_ONE;
          end
        end
        L_RS_REL: begin
          if (rateDone) begin
            sclDrive <= FLAG_OFF;
            state    <= L_RS_WAIT;
          end else begin
            rate_counter <= rate_counter - RATE_ONE;
          end
        end
        L_RS_WAIT: begin
          if (sclSync && !sdaSync) begin
            state       <= L_IDLE;
            sdaDrive    <= FLAG_OFF;
            doneCollide <= FLAG_ON;
            doneToggle  <= ~doneToggle;
          end else if (sclSync) begin
            rate_counter <= cmd.reload;
            state        <= L_ST_HIGH;
          end
        end
        L_AK_LOW: begin
          if (rateDone) begin
            sclDrive <= FLAG_OFF;
            state    <= L_AK_WAIT;
          end else begin
            rate_counter <= rate_counter - RATE_ONE;
          end
        end
        L_AK_WAIT: begin
          if (sclSync) begin
            rate_counter <= cmd.reload;
            state        <= L_AK_HIGH;
          end
        end
        L_AK_HIGH: begin
          if (rateDone) begin
            sclDrive   <= FLAG_ON;
            state      <= L_IDLE;
            doneToggle <= ~doneToggle;
          end else begin
            rate_counter <= rate_counter - RATE_ONE;
          end
        end
        L_SP_DRIVE: begin
          if (!sdaSync) begin
            rate_counter <= cmd.reload;
            state        <= L_SP_LOW;
          end
        end
        L_SP_LOW: begin
          if (rateDone) begin
            sclDrive     <= FLAG_OFF;
            rate_counter <= cmd.reload;
            state        <= L_SP_REL;
          end else begin
            rate_counter <= rate_counter - RATE_ONE;
          end
        end
        L_SP_REL: begin
          if (rateDone) begin
            sdaDrive <= FLAG_OFF;
            state    <= L_SP_WAIT;
          end else begin
            rate_counter <= rate_counter - RATE_ONE;
          end
        end
        L_SP_WAIT: begin
          if (sdaSync && sclSync) begin
            rate_counter <= cmd.reload;
            state        <= L_SP_DONE;
          end
        end
        L_SP_DONE: begin
          if (rateDone) begin
            state      <= L_IDLE;
            doneToggle <= ~doneToggle;
          end else begin
            rate_counter <= rate_counter - RATE_ONE;
          end
        end
        L_TX_LOW: begin
          if (rateDone) begin
            sclDrive <= FLAG_OFF;
            state    <= L_TX_WAIT;
          end else begin
            rate_counter <= rate_counter - RATE_ONE;
          end
        end
        L_TX_WAIT: begin
          if (sclSync) begin
            rate_counter <= cmd.reload;
            state        <= L_TX_HIGH;
          end
        end
        L_TX_HIGH: begin
          if (rateDone) begin
            sclDrive <= FLAG_ON;
            if (bitIdx == BIT_ACK) begin
              // clock stays low until the next request
              doneAck    <= sdaSync;
              state      <= L_IDLE;
              doneToggle <= ~doneToggle;
            end else begin
              bitIdx       <= bitIdx + BIT_ONE;
              shifter      <= {shifter[DATA_MSB-1:0], LINE_LOW};
              sdaDrive     <= (bitIdx == BIT_LAST) ? FLAG_OFF :
                              ~shifter[DATA_MSB-1];
              rate_counter <= cmd.reload;
              state        <= L_TX_LOW;
            end
          end else begin
            rate_counter <= rate_counter - RATE_ONE;
          end
        end
        default: begin
          state    <= L_IDLE;
          sclDrive <= FLAG_OFF;
          sdaDrive <= FLAG_OFF;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pins: open drain, enable high pulls the line low
  // ----------------------------------------------------------------
  always_ff @(posedge linkClk) begin
    if (!linkRstn) begin
      sclOut <= LINE_LOW;
      sdaOut <= LINE_LOW;
      sclOe  <= FLAG_OFF;
      sdaOe  <= FLAG_OFF;
    end else begin
      sclOut <= LINE_LOW;
      sdaOut <= LINE_LOW;
      sclOe  <= sclDrive;
      sdaOe  <= sdaDrive;
    end
  end

endmodule

// ==== bench/ihs_host_seq_chk.sv ====
// assertion checker for the host sequencer ports
module ihs_host_seq_chk (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic moduleEnable,
  input wire logic ackSet,
  input wire logic bufWrite,
  input wire logic start_sequence_enable,
  input wire logic restart_sequence_enable,
  input wire logic stop_sequence_enable,
  input wire logic ack_sequence_enable,
  input wire logic write_collision_flag,
  input wire logic buffer_full_flag,
  input wire logic port_event_flag,
  input wire logic bus_collision_flag,
  input wire logic startDetected,
  input wire logic stopDetected
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy;
  assign busy = start_sequence_enable | restart_sequence_enable |
    stop_sequence_enable | ack_sequence_enable | buffer_full_flag;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  a_ack_taken: assert property (ackSet && moduleEnable && !busy
    |=> ack_sequence_enable) else $error("ack request lost");
  a_ack_write_collision_flag: assert property (bufWrite && ack_sequence_enable
    && moduleEnable |=> write_collision_flag) else $error("ack write");
  a_stop_write_collision_flag: assert property (bufWrite && stop_sequence_enable
    && moduleEnable |=> write_collision_flag) else $error("stop write");
  a_reset_clear: assert property (disable iff (1'b0) !resetn
    |=> !busy && !startDetected && !stopDetected) else $error("reset");
  a_off_clear: assert property (!moduleEnable [*6]
    |-> !startDetected && !stopDetected) else $error("detect kept");
  a_ack_finish: assert property ($fell(ack_sequence_enable)
    && $past(moduleEnable) |-> port_event_flag || bus_collision_flag)
    else $error("ack ended without flag");
  a_stop_finish: assert property ($fell(stop_sequence_enable)
    && $past(moduleEnable) |-> port_event_flag && stopDetected)
    else $error("stop ended without flags");
  a_coll_release: assert property ($rose(bus_collision_flag)
    |-> !buffer_full_flag && !start_sequence_enable &&
    !ack_sequence_enable) else $error("sequence kept after collision");
endmodule

bind ihs_host_seq ihs_host_seq_chk chk (.*);

// ==== bench/ihs_bus_model.sv ====
// bus model: pull-ups, an acking target and a rival controller
module ihs_bus_model (
  input  wire logic sclOe,
  input  wire logic sdaOe,
  input  wire logic rivalScl,
  input  wire logic rivalSda,
  output logic      sclIn,
  output logic      sdaIn
);
  timeunit 1ns;
  timeprecision 1ps;
  int falls = 0;
  // released lines float high; target acks through the ninth clock
  assign sclIn = !(sclOe || rivalScl);
  assign sdaIn = !(sdaOe || rivalSda || falls == 9);
  // a start on the bus restarts the clock count
  always @(negedge sdaIn) if (sclIn) falls = 0;
  always @(negedge sclIn) falls = falls + 1;
endmodule

// ==== bench/ihs_host_seq_bench.sv ====
// self-checking bench for the two-wire host sequencer
module ihs_host_seq_bench
  import ihs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, linkClk = 0, resetn = 0, moduleEnable = 0;
  logic startSet = 0, restartSet = 0, stopSet = 0, ackSet = 0;
  logic ack_data_value = 0, bufWrite = 0, writeCollisionClear = 0;
  logic portEventClear = 0, busCollisionClear = 0, sclIn, sdaIn;
  logic rivalScl = 0, rivalSda = 0;
  logic [RATE_W-1:0] rate_reload_register = 8'h0A;
  logic [DATA_W-1:0] bufWriteData = 8'h00;
  logic [15:0] seenBits = 16'h0000;
  logic start_sequence_enable, restart_sequence_enable;
  logic stop_sequence_enable, ack_sequence_enable, write_collision_flag;
  logic buffer_full_flag, port_event_flag, bus_collision_flag;
  logic startDetected, stopDetected, ackStatus, sclOut, sclOe, sdaOut, sdaOe;
  int mismatches = 0, compares = 0;
  ihs_host_seq dut (.*);
  ihs_bus_model bus (.*);
  always #10 clk_sys = ~clk_sys;
  always #16 linkClk = ~linkClk;
  always @(posedge sclIn) seenBits <= {seenBits[14:0], sdaIn};
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // k: 0 start, 1 restart, 2 stop, 3 ack, 4 buffer write
  task automatic req(int k);
    {startSet, restartSet, stopSet, ackSet, bufWrite} <= 5'h10 >> k;
    @(posedge clk_sys);
    {startSet, restartSet, stopSet, ackSet, bufWrite} <= 5'h00;
    @(posedge clk_sys);
  endtask
  task automatic waitIdle();
    int n;
    n = 0;
    while ((start_sequence_enable | restart_sequence_enable |
        stop_sequence_enable | ack_sequence_enable | buffer_full_flag)
        !== 1'b0 && n < 4000) begin
      @(posedge clk_sys);
      n++;
    end
    check("idle", n < 4000, 1);
  endtask
  task automatic done(string name);
    $display("test %s finished", name);
    {writeCollisionClear, portEventClear, busCollisionClear} <= 3'h7;
    @(posedge clk_sys);
    {writeCollisionClear, portEventClear, busCollisionClear} <= 3'h0;
    @(posedge clk_sys);
  endtask
  task automatic send(logic [7:0] d);
    bufWriteData <= d;
    req(4);
    check("full", buffer_full_flag, 1);
    waitIdle();
    check("bits", seenBits[8:1], d);
    check("ack", {seenBits[0], ackStatus}, 2'h0);
    done("send");
  endtask
  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clk_sys);
    mismatches++;
    finish_test();
  end
  initial begin
    void'($urandom(3));
    // reset spans five link edges as well
    repeat (8) @(posedge clk_sys);
    resetn <= 1;
    moduleEnable <= 1;
    repeat (12) @(posedge clk_sys);
    rate_reload_register <= 8'h08 + 8'($urandom % 8);
    req(0);
    check("start", start_sequence_enable, 1);
    waitIdle();
    check("start event", {port_event_flag, sclIn}, 2'h2);
    done("start");
    send(8'($urandom));
    for (int v = 0; v < 2; v++) begin
      ack_data_value <= v[0];
      req(3);
      req(4);
      check("ack write_collision_flag", write_collision_flag, 1);
      repeat (4) @(posedge clk_sys);
      check("ack lines", {sclOe, sdaOe}, {1'b1, !v[0]});
      waitIdle();
      check("ack end", {port_event_flag, sclOe}, 2'h3);
      done("ack");
    end
    req(1);
    check("restart on", restart_sequence_enable, 1);
    waitIdle();
    check("restart", {port_event_flag, restart_sequence_enable}, 2'h2);
    done("restart");
    send(8'($urandom));
    req(2);
    req(4);
    check("stop write_collision_flag", write_collision_flag, 1);
    repeat (4) @(posedge clk_sys);
    check("stop drive", {sclOe, sdaOe}, 2'h3);
    waitIdle();
    check("stop", {stopDetected, port_event_flag}, 2'h3);
    check("free", {sclIn, sdaIn}, 2'h3);
    done("stop");
    rivalScl <= 1;
    req(0);
    waitIdle();
    check("start clash", bus_collision_flag, 1);
    rivalScl <= 0;
    done("start clash");
    req(0);
    waitIdle();
    done("start");
    rivalSda <= 1;
    bufWriteData <= 8'hFF;
    req(4);
    waitIdle();
    check("send clash", bus_collision_flag, 1);
    check("released", {sclOe, sdaOe, sclOut, sdaOut}, 4'h0);
    done("send clash");
    rivalSda <= 0;
    repeat (12) @(posedge clk_sys);
    check("bus stop", port_event_flag, 1);
    req(0);
    waitIdle();
    send(8'($urandom));
    done("resend");
    ack_data_value <= 1;
    rivalSda <= 1;
    req(3);
    waitIdle();
    check("ack clash", bus_collision_flag, 1);
    done("ack clash");
    rivalSda <= 0;
    repeat (12) @(posedge clk_sys);
    for (int k = 0; k < 2; k++) begin
      req(0);
      repeat (3) @(posedge clk_sys);
      if (k == 0) moduleEnable <= 0;
      else resetn <= 0;
      repeat (8) @(posedge clk_sys);
      check("abort", {start_sequence_enable, sclOe, sdaOe}, 3'h0);
      check("detect", {startDetected, stopDetected}, 2'h0);
      resetn <= 1;
      moduleEnable <= 1;
      repeat (12) @(posedge clk_sys);
      done("abort");
    end
    finish_test();
  end
endmodule
